// >>> hdl/fbm_unit.sv
// Added by the designer: the strobed register port and the register addresses.
`include "fbm_map.svh"
`default_nettype none
module fbm_unit
   import fbm_pkg::*;
#(
   parameter int DATA_W = 32
)(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // instruction issue
   input  wire logic              instrValid,
   input  wire fbm_instr_t        instrWord,
   output logic                   instrReady,
   output logic                   instrDone,
   // register port
   input  wire fbm_bus_req_t      busReq,
   output logic      [31:0]       busRdData,
   // flags
   output logic                   zeroFlag,
   output logic                   carryFlag
);

   ////////////////////////////////////////////////////////////////////////
   // parameter check
   if (DATA_W < `FBM_IMM_W || DATA_W > 32)
   begin : g_bad_width
      $error("fbm_unit: DATA_W must lie between 9 and 32");
   end

   fbm_state_t          state;
   fbm_state_t          next_state;
   fbm_instr_t          cur;
   logic                accept;
   logic                supported;
   logic                flagIn;
   logic                zeroSnap;
   logic                carrySnap;
   logic [DATA_W-1:0]   dstVal;
   logic [DATA_W-1:0]   maskVal;
   logic [DATA_W-1:0]   result;
   logic [DATA_W-1:0]   ramDst;
   logic [DATA_W-1:0]   ramMask;
   logic [DATA_W-1:0]   ramBus;
   logic [8:0]          rdAddrDst;
   logic [8:0]          rdAddrSrc;
   logic                coreWr;
   logic                busMemWr;
   logic                ramWrEn;
   logic [8:0]          ramWrAddr;
   logic [DATA_W-1:0]   ramWrData;
   logic                badOp;
   logic                rdFromMem;
   logic [31:0]         rdRegData;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic oddParity(input logic [DATA_W-1:0] v);
      oddParity = ^v;
   endfunction

   // forces the masked bits to one value and keeps the rest
   function automatic logic [DATA_W-1:0] maskSet(
      input logic [DATA_W-1:0] d,
      input logic [DATA_W-1:0] m,
      input logic              b
   );
      maskSet = (d & ~m) | (m & {DATA_W{b}});
   endfunction

   function automatic logic isMaskOp(input logic [5:0] op);
      isMaskOp = (op == `FBM_OP_SET_CARRY) ||
                 (op == `FBM_OP_SET_NOT_CARRY) ||
                 (op == `FBM_OP_SET_NOT_ZERO);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // sequencing: accept, read, execute, write, finish
   // a new word is taken in the finish cycle so the rate is one per four
   assign instrReady = (state == ST_IDLE) || (state == ST_FINISH);
   assign accept     = instrValid && instrReady;
   assign instrDone  = (state == ST_FINISH);
   assign supported  = isMaskOp(cur.opcode);

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:   next_state = accept ? ST_READ : ST_IDLE;
         ST_READ:   next_state = ST_EXEC;
         ST_EXEC:   next_state = ST_WRITE;
         ST_WRITE:  next_state = ST_FINISH;
         ST_FINISH: next_state = accept ? ST_READ : ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // the issued word is held for the whole instruction
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cur <= '0;
      end
      else if (accept)
      begin
         cur <= instrWord;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operand fetch
   // field decode for the reads
   assign rdAddrDst = accept ? instrWord.dst : cur.dst;
   assign rdAddrSrc = accept ? instrWord.src : cur.src;

   // core writes win the single write port; a colliding port write is lost
   // write-back unless suppressed
   assign coreWr    = (state == ST_WRITE) && supported && cur.wrResult;
   assign busMemWr  = busReq.wr && (busReq.addr[9] == 1'b0);
   assign ramWrEn   = coreWr || busMemWr;
   assign ramWrAddr = coreWr ? cur.dst : busReq.addr[8:0];
   assign ramWrData = coreWr ? result : busReq.wdata[DATA_W-1:0];

   fbm_reg_ram #(
      .DATA_W (DATA_W),
      .ADDR_W (`FBM_REG_AW)
   ) u_ram (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .rdAddrA (rdAddrDst),
      .rdAddrB (rdAddrSrc),
      .rdAddrC (busReq.addr[8:0]),
      .rdDataA (ramDst),
      .rdDataB (ramMask),
      .rdDataC (ramBus),
      .wrEn    (ramWrEn),
      .wrAddr  (ramWrAddr),
      .wrData  (ramWrData)
   );

   // capture operands and a flag snapshot at the end of the read cycle
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         dstVal    <= '0;
         maskVal   <= '0;
         zeroSnap  <= 1'b0;
         carrySnap <= 1'b0;
      end
      else if (state == ST_READ)
      begin
         dstVal    <= ramDst;
         maskVal   <= cur.immMask ?
                      {{(DATA_W-`FBM_IMM_W){1'b0}}, cur.src} : ramMask;
         zeroSnap  <= zeroFlag;
         carrySnap <= carryFlag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // execute
   // flag source per opcode
   always_comb
   begin
      case (cur.opcode)
         `FBM_OP_SET_CARRY:     flagIn = carrySnap;
         `FBM_OP_SET_NOT_CARRY: flagIn = ~carrySnap;
         `FBM_OP_SET_NOT_ZERO:  flagIn = ~zeroSnap;
         default:               flagIn = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         result <= '0;
      end
      else if (state == ST_EXEC)
      begin
         result <= maskSet(dstVal, maskVal, flagIn);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags; an instruction update wins over a port write in the same cycle
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         zeroFlag <= `FBM_RST_ZERO;
      end
      else if ((state == ST_WRITE) && supported && cur.wrZero)
      begin
         zeroFlag <= (result == '0);
      end
      else if (busReq.wr && (busReq.addr == `FBM_ADDR_FLAGS))
      begin
         zeroFlag <= busReq.wdata[`FBM_FLAG_ZERO_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         carryFlag <= `FBM_RST_CARRY;
      end
      else if ((state == ST_WRITE) && supported && cur.wrCarry)
      begin
         carryFlag <= oddParity(result);
      end
      else if (busReq.wr && (busReq.addr == `FBM_ADDR_FLAGS))
      begin
         carryFlag <= busReq.wdata[`FBM_FLAG_CARRY_BIT];
      end
   end

   // an opcode outside the three completes with no effect, noted here
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         badOp <= 1'b0;
      end
      else if (state == ST_WRITE)
      begin
         badOp <= !supported;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port reads, data in the following cycle
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rdFromMem <= 1'b0;
         rdRegData <= '0;
      end
      else
      begin
         rdFromMem <= busReq.rd && (busReq.addr[9] == 1'b0);
         rdRegData <= '0;
         if (busReq.rd && (busReq.addr == `FBM_ADDR_FLAGS))
         begin
            rdRegData[`FBM_FLAG_ZERO_BIT]  <= zeroFlag;
            rdRegData[`FBM_FLAG_CARRY_BIT] <= carryFlag;
         end
         else if (busReq.rd && (busReq.addr == `FBM_ADDR_STATUS))
         begin
            rdRegData[`FBM_STAT_BUSY_BIT]  <= (state != ST_IDLE);
            rdRegData[`FBM_STAT_BADOP_BIT] <= badOp;
         end
      end
   end

   // both sources are flops; unmapped addresses read zero
   assign busRdData = rdFromMem ? 32'(ramBus) : rdRegData;

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [DATA_W-1:0] chkOld;
   assign chkOld = dstVal & ~maskVal;

   a_four_clock_done:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      accept |-> ##1 !instrDone ##1 !instrDone ##1 !instrDone ##1 instrDone)
   else $error("instruction did not finish in four clocks");

   a_carry_to_mask:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      coreWr && (cur.opcode == `FBM_OP_SET_CARRY)
      |-> (ramWrData & maskVal) == (maskVal & {DATA_W{carrySnap}}))
   else $error("masked bits differ from carry");

   a_ncarry_to_mask:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      coreWr && (cur.opcode == `FBM_OP_SET_NOT_CARRY)
      |-> (ramWrData & maskVal) == (maskVal & {DATA_W{!carrySnap}}))
   else $error("masked bits differ from inverted carry");

   a_nzero_to_mask:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      coreWr && (cur.opcode == `FBM_OP_SET_NOT_ZERO)
      |-> (ramWrData & maskVal) == (maskVal & {DATA_W{!zeroSnap}}))
   else $error("masked bits differ from inverted zero");

   a_unmasked_kept:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      coreWr |-> (ramWrData & ~maskVal) == chkOld)
   else $error("unmasked destination bit changed");

   a_zero_effect:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      (state == ST_WRITE) && supported && cur.wrZero
      |=> zeroFlag == ($past(result) == '0))
   else $error("zero flag does not match result");

   a_parity_effect:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      (state == ST_WRITE) && supported && cur.wrCarry
      |=> carryFlag == $countones($past(result)) % 2)
   else $error("carry flag does not match parity");

   a_no_result:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      (state == ST_WRITE) && supported
      |-> (ramWrEn && ramWrAddr == cur.dst) == cur.wrResult
          || (!cur.wrResult && busMemWr))
   else $error("write-back does not follow result effect");

   a_imm_mask:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      (state == ST_EXEC) && cur.immMask
      |-> maskVal[DATA_W-1:`FBM_IMM_W] == '0 &&
          maskVal[`FBM_IMM_W-1:0] == cur.src)
   else $error("immediate mask not zero-extended");

   a_field_decode:
   assert property (@(posedge clk_sys) disable iff (!resetn)
      accept |=> cur.dst == $past(instrWord.dst) &&
                 cur.src == $past(instrWord.src))
   else $error("operand fields not latched");

endmodule // fbm_unit
`default_nettype wire

// >>> hdl/fbm_map.svh
`ifndef FBM_MAP_SVH
`define FBM_MAP_SVH
// opcode field values of the three masked flag-set instructions
`define FBM_OP_SET_CARRY     6'h1C
`define FBM_OP_SET_NOT_CARRY 6'h1D
`define FBM_OP_SET_NOT_ZERO  6'h1F
// instruction geometry
`define FBM_IMM_W            9
`define FBM_REG_AW           9
// register port map, word indices
`define FBM_BUS_AW           10
`define FBM_ADDR_FLAGS       10'h200
`define FBM_ADDR_STATUS      10'h201
// field positions in the flag and status words
`define FBM_FLAG_ZERO_BIT    0
`define FBM_FLAG_CARRY_BIT   1
`define FBM_STAT_BUSY_BIT    0
`define FBM_STAT_BADOP_BIT   1
// reset values of the flags
`define FBM_RST_ZERO         1'h0
`define FBM_RST_CARRY        1'h0
// clocks per instruction and the core clock period in ns
`define FBM_INSTR_CLOCKS     4
`define FBM_CLK_PERIOD_NS    8
`endif

// >>> hdl/fbm_pkg.sv
`default_nettype none
package fbm_pkg;
   // instruction word as the core sees it, msb first
   typedef struct packed {
      logic [5:0] opcode;
      logic       wrZero;  // write_zero_flag_effect
      logic       wrCarry; // write_carry_flag_effect
      logic       wrResult; // low means no_result_write_effect
      logic       immMask;
      logic [3:0] cond;
      logic [8:0] dst;
      logic [8:0] src;
   } fbm_instr_t;

   // one request of the plain register port
   typedef struct packed {
      logic [9:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fbm_bus_req_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_EXEC,
      ST_WRITE,
      ST_FINISH
   } fbm_state_t;
endpackage
`default_nettype wire

// >>> hdl/fbm_reg_ram.sv
`default_nettype none
module fbm_reg_ram
   import fbm_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 9
)(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // three read ports, data one cycle after the address
   input  wire logic [ADDR_W-1:0] rdAddrA,
   input  wire logic [ADDR_W-1:0] rdAddrB,
   input  wire logic [ADDR_W-1:0] rdAddrC,
   output logic      [DATA_W-1:0] rdDataA,
   output logic      [DATA_W-1:0] rdDataB,
   output logic      [DATA_W-1:0] rdDataC,
   // single write port
   input  wire logic              wrEn,
   input  wire logic [ADDR_W-1:0] wrAddr,
   input  wire logic [DATA_W-1:0] wrData
);

   logic [DATA_W-1:0] mem [2**ADDR_W];

   ////////////////////////////////////////////////////////////////////////
   // storage has no reset; software loads it before use
   always_ff @(posedge clk_sys)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read data, old value on a same-cycle write
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rdDataA <= '0;
         rdDataB <= '0;
         rdDataC <= '0;
      end
      else
      begin
         rdDataA <= mem[rdAddrA];
         rdDataB <= mem[rdAddrB];
         rdDataC <= mem[rdAddrC];
      end
   end
endmodule // fbm_reg_ram
`default_nettype wire

// >>> tb/fbm_unit_tb.sv
`include "fbm_map.svh"
`default_nettype none
module tb
   import fbm_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   // one compare, counted; a mismatch is printed at once
   `define CHK(a, b) \
   begin \
      checked++; \
      if ((a) !== (b)) \
      begin \
         errTotal++; \
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); \
      end \
   end

   ////////////////////////////////////////////////////////////////////////
   // clock, reset and design ports
   logic         clk_sys = 1'b0;
   logic         resetn;
   logic         instrValid;
   fbm_instr_t   instrWord;
   logic         instrReady;
   logic         instrDone;
   fbm_bus_req_t busReq;
   logic [31:0]  busRdData;
   logic         zeroFlag;
   logic         carryFlag;
   int           errTotal = 0;
   int           checked = 0;

   // destination and mask pairs, run for each opcode and flag state
   logic [31:0]  dstTab [4] = '{32'h0000_0000, 32'h0000_0000,
                                32'hAA55_2200, 32'hAA55_2200};
   logic [31:0]  maskTab [4] = '{32'h0000_0001, 32'h0000_0003,
                                 32'h1234_5678, 32'hFFFF_FFFF};
   logic [5:0]   opTab [3] = '{`FBM_OP_SET_CARRY, `FBM_OP_SET_NOT_CARRY,
                               `FBM_OP_SET_NOT_ZERO};

   fbm_unit #(.DATA_W(32)) dut (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .instrValid (instrValid),
      .instrWord  (instrWord),
      .instrReady (instrReady),
      .instrDone  (instrDone),
      .busReq     (busReq),
      .busRdData  (busRdData),
      .zeroFlag   (zeroFlag),
      .carryFlag  (carryFlag)
   );

   // free-running core clock, 8 ns period
   initial
   begin
      forever #4 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   // verdict; also reached when a bounded wait runs out
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // one-cycle write strobe on the register port
   task automatic busWr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      busReq <= '0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic busRd(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      busReq <= '0;
      #1;
      d = busRdData;
   endtask

   // issue one instruction, eff = {zero write, carry write, write-back}
   task automatic exec(input logic [5:0] op, input logic [2:0] eff,
                       input logic imm, input logic [8:0] dst,
                       input logic [8:0] src);
      fbm_instr_t w;
      w = '{op, eff[2], eff[1], eff[0], imm, 4'hF, dst, src};
      @(posedge clk_sys);
      instrValid <= 1'b1;
      instrWord  <= w;
      @(posedge clk_sys);
      instrValid <= 1'b0;
      #1;
      waitDone();
   endtask

   // called just after the taking edge; a hung core must not stall the run
   task automatic waitDone;
      int n;
      n = 0;
      while (instrDone !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 20)
      begin
         errTotal++;
         summarize();
      end
      else
      begin
         `CHK(n, 3)
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // flags come out of reset clear and the unmapped space reads zero
   task automatic tReset;
      logic [31:0] d;
      `CHK({zeroFlag, carryFlag, instrReady}, 3'b001)
      busRd(`FBM_ADDR_FLAGS, d);
      `CHK(d, 32'h0000_0000)
      busWr(10'h3FF, 32'hDEAD_BEEF);
      busRd(10'h3FF, d);
      `CHK(d, 32'h0000_0000)
   endtask

   // every opcode, every pair, both flag states; the unused flag is
   // set opposite so a wrong flag source shows up
   task automatic tTable;
      logic [31:0] d;
      logic [31:0] exp;
      logic        b;
      for (int k = 0; k < 3; k++)
         for (int r = 0; r < 4; r++)
            for (int f = 0; f < 2; f++)
            begin
               b = (k == 0) ? f[0] : ~f[0];
               exp = (dstTab[r] & ~maskTab[r]) | (b ? maskTab[r] : 32'h0);
               busWr(10'h005, dstTab[r]);
               busWr(10'h00A, maskTab[r]);
               if (k == 2)
                  busWr(`FBM_ADDR_FLAGS, {30'h0, ~f[0], f[0]});
               else
                  busWr(`FBM_ADDR_FLAGS, {30'h0, f[0], ~f[0]});
               exec(opTab[k], 3'b111, 1'b0, 9'h005, 9'h00A);
               busRd(10'h005, d);
               `CHK(d, exp)
               `CHK(zeroFlag, (exp == 32'h0))
               `CHK(carryFlag, ^exp)
            end
   endtask

   // flags update without write-back, then write-back without flags
   task automatic tEffects;
      logic [31:0] d;
      busWr(10'h007, 32'h0000_00F0);
      busWr(10'h008, 32'h0000_000F);
      busWr(`FBM_ADDR_FLAGS, 32'h0000_0003);
      exec(`FBM_OP_SET_CARRY, 3'b110, 1'b0, 9'h007, 9'h008);
      busRd(10'h007, d);
      `CHK(d, 32'h0000_00F0)
      `CHK({zeroFlag, carryFlag}, 2'b00)
      busWr(`FBM_ADDR_FLAGS, 32'h0000_0002);
      exec(`FBM_OP_SET_CARRY, 3'b001, 1'b0, 9'h007, 9'h008);
      busRd(10'h007, d);
      `CHK(d, 32'h0000_00FF)
      `CHK({zeroFlag, carryFlag}, 2'b01)
   endtask

   // immediate mask: register at the same index must not be used,
   // and the nine bits are not sign-extended
   task automatic tImmediate;
      logic [31:0] d;
      busWr(10'h1AB, 32'h0000_0000);
      busWr(10'h1FF, 32'hFFFF_FFFF);
      busWr(`FBM_ADDR_FLAGS, 32'h0000_0002);
      exec(`FBM_OP_SET_CARRY, 3'b111, 1'b1, 9'h1AB, 9'h1FF);
      busRd(10'h1AB, d);
      `CHK(d, 32'h0000_01FF)
      `CHK({zeroFlag, carryFlag}, 2'b01)
   endtask

   // an opcode outside the three changes nothing and is reported
   task automatic tStatus;
      logic [31:0] d;
      busWr(10'h00C, 32'h1234_5678);
      busWr(`FBM_ADDR_FLAGS, 32'h0000_0003);
      exec(6'h00, 3'b111, 1'b1, 9'h00C, 9'h1FF);
      busRd(10'h00C, d);
      `CHK(d, 32'h1234_5678)
      `CHK({zeroFlag, carryFlag}, 2'b11)
      busRd(`FBM_ADDR_STATUS, d);
      `CHK(d, 32'h0000_0002)
   endtask

   // a held request is refused while busy and taken in the done cycle;
   // the second word reads back what the first has just written
   task automatic tBackToBack;
      logic [31:0] d;
      fbm_instr_t  w1;
      fbm_instr_t  w2;
      w1 = '{`FBM_OP_SET_CARRY, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 9'h010,
             9'h00F};
      w2 = '{`FBM_OP_SET_NOT_CARRY, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 9'h010,
             9'h003};
      busWr(10'h010, 32'h0000_0000);
      busWr(`FBM_ADDR_FLAGS, 32'h0000_0002);
      @(posedge clk_sys);
      instrValid <= 1'b1;
      instrWord  <= w1;
      @(posedge clk_sys);
      instrWord  <= w2;
      #1;
      `CHK(instrReady, 1'b0)
      waitDone();
      @(posedge clk_sys);
      instrValid <= 1'b0;
      #1;
      waitDone();
      busRd(10'h010, d);
      `CHK(d, 32'h0000_000C)
      busRd(`FBM_ADDR_STATUS, d);
      `CHK(d, 32'h0000_0000)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence: reset held for 8 clocks, then each scenario
   initial
   begin
      resetn     = 1'b0;
      instrValid = 1'b0;
      instrWord  = '0;
      busReq     = '0;
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      tReset();
      tTable();
      tEffects();
      tImmediate();
      tStatus();
      tBackToBack();
      summarize();
   end
endmodule // tb
`default_nettype wire
